//--- hw/snooze_pkg.sv
// Purpose: Shared constants and types for the alarm, snooze and wake sequencer
// Assumes: 100 MHz pclk, APB register access, mains pulses on a pin
// Notes: Offsets are byte addresses of 32-bit words
package snooze_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TIME = 8'h08;
  localparam logic [7:0] OFF_ALARM = 8'h0C;
  localparam logic [7:0] OFF_SLEEP = 8'h10;
  localparam int CTRL_BUZZER = 0;
  localparam int CTRL_DELAY = 1;
  localparam int CTRL_TAPE = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [6:0] SLEEP_RESET = 7'h3C;
  localparam int ST_ACTIVE = 0;
  localparam int ST_PHASE = 1;
  localparam int ST_FMT12 = 3;
  localparam int ST_HZ60 = 4;
  localparam int ST_SLEEP = 5;
  localparam int ST_STOPPED = 6;
  localparam int TM_MIN = 0;
  localparam int TM_HR = 8;
  localparam int CLK_HZ = 100000000;
  localparam int DEBOUNCE_MS = 20;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam logic [2:0] SNOOZE_MIN = 3'h5;
  localparam logic [6:0] TIMEOUT_MIN = 7'h50;
  localparam logic [6:0] SLEEP_MAX_MIN = 7'h78;
  localparam logic [5:0] DIV50_MAX = 6'h31;
  localparam logic [5:0] DIV60_MAX = 6'h3B;
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [5:0] HR_MAX = 6'h17;
  localparam logic [2:0] STRAP_WAIT = 3'h7;
  localparam int BTN_SNOOZE = 1;
  localparam int BTN_SLEEP = 0;

  typedef enum logic [1:0] {PH_IDLE, PH_LOUD, PH_LOW, PH_OFF} phase_t;

  typedef struct packed {
    logic mains;
    logic set_time_n;
    logic set_alarm_n;
    logic snooze_cancel_input_n;
    logic sleep_initiate_input_n;
    logic wake1_i;
    logic wake2_i;
  } pins_t;
endpackage : snooze_pkg

//--- hw/alarm_snooze_wake_sequencer.sv
// Purpose: Alarm, snooze, sleep and wake-output sequencing of a clock-radio timekeeper
// Assumes: pins are asynchronous, buttons are active low, wake and sleep pins are open drain
// Notes: Summary of operation follows
`timescale 1ns/10ps
`default_nettype none

module alarm_snooze_wake_sequencer #(
  parameter int DEBOUNCE_CYCLES = snooze_pkg::DEBOUNCE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire snooze_pkg::pins_t pins,
  output logic wake1_o,
  output logic wake1_oe_n,
  output logic wake2_o,
  output logic wake2_oe_n,
  output logic sleep_o,
  output logic sleep_oe_n,
  output logic radio_on,
  output logic radio_low_volume,
  output logic buzzer_on
);
  import snooze_pkg::*;

  localparam int DBW = $clog2(DEBOUNCE_CYCLES + 1);

  function automatic logic [5:0] inc_wrap(input logic [5:0] v, input logic [5:0] max);
    inc_wrap = (v == max) ? 6'h00 : v + 6'h01;
  endfunction : inc_wrap

  // Input synchronisers, three stages plus an agreement stage
  logic [6:0] s1, s2, s3, sq, next_sq;
  pins_t in_s;
  genvar g;
  for (g = 0; g < 7; g++) begin : g_sync
    assign next_sq[g] = (s2[g] == s3[g]) ? s3[g] : sq[g];
  end
  assign in_s = sq;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 7'h7F;
      s2 <= 7'h7F;
      s3 <= 7'h7F;
      sq <= 7'h7F;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      sq <= next_sq;
    end
  end

  // Button debounce; a long hold gives one press only
  logic [1:0] btn_n;
  logic [1:0] press;
  assign btn_n = {in_s.snooze_cancel_input_n, in_s.sleep_initiate_input_n};
  for (g = 0; g < 2; g++) begin : g_deb
    logic [DBW-1:0] cnt, next_cnt;
    logic low, next_low, pr, next_pr;
    always_comb begin
      next_cnt = cnt;
      next_low = low;
      if (btn_n[g]) begin
        next_cnt = '0;
        next_low = 1'b0;
      end else if (cnt == DBW'(DEBOUNCE_CYCLES)) begin
        next_low = 1'b1;
      end else begin
        next_cnt = cnt + DBW'(1);
      end
      next_pr = next_low & ~low;
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt <= '0;
        low <= 1'b0;
        pr <= 1'b0;
      end else begin
        cnt <= next_cnt;
        low <= next_low;
        pr <= next_pr;
      end
    end
    assign press[g] = pr;
  end

  // Capture runs past the synchroniser fill, else the reset value is taken as the strap
  logic [2:0] strap_cnt, next_strap_cnt;
  logic fmt12, next_fmt12, hz60, next_hz60;
  always_comb begin
    next_strap_cnt = strap_cnt;
    next_fmt12 = fmt12;
    next_hz60 = hz60;
    if (strap_cnt != STRAP_WAIT) begin
      next_strap_cnt = strap_cnt + 3'h1;
      next_fmt12 = in_s.wake1_i;
      next_hz60 = in_s.wake2_i;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt <= 3'h0;
      fmt12 <= 1'b0;
      hz60 <= 1'b0;
    end else begin
      strap_cnt <= next_strap_cnt;
      fmt12 <= next_fmt12;
      hz60 <= next_hz60;
    end
  end

  // Time base and time or alarm setting
  logic time_set, alarm_set, alarm_req;
  assign time_set = ~in_s.set_time_n & in_s.set_alarm_n;
  assign alarm_set = in_s.set_time_n & ~in_s.set_alarm_n;
  assign alarm_req = ~in_s.set_time_n & ~in_s.set_alarm_n;

  logic mains_prev, next_mains_prev, stopped, next_stopped, min_tick, next_min_tick;
  logic [5:0] div, next_div, sec, next_sec, tmin, next_tmin, thr, next_thr;
  logic [5:0] amin, next_amin, ahr, next_ahr;
  always_comb begin
    next_mains_prev = in_s.mains;
    next_div = div;
    next_sec = sec;
    next_tmin = tmin;
    next_thr = thr;
    next_amin = amin;
    next_ahr = ahr;
    next_stopped = stopped & time_set;
    next_min_tick = 1'b0;
    if (in_s.mains & ~mains_prev & ~stopped) begin
      next_div = inc_wrap(div, hz60 ? DIV60_MAX : DIV50_MAX);
      if (div == (hz60 ? DIV60_MAX : DIV50_MAX)) begin
        next_sec = inc_wrap(sec, SEC_MAX);
        if (sec == SEC_MAX) begin
          next_min_tick = 1'b1;
          next_tmin = inc_wrap(tmin, MIN_MAX);
          if (tmin == MIN_MAX) begin
            next_thr = inc_wrap(thr, HR_MAX);
          end
        end
      end
    end
    // Setting beats the running count, and minutes never carry
    if (time_set & press[BTN_SLEEP]) begin
      next_thr = inc_wrap(thr, HR_MAX);
    end
    if (time_set & press[BTN_SNOOZE]) begin
      next_tmin = inc_wrap(tmin, MIN_MAX);
      next_sec = 6'h00;
      next_div = 6'h00;
      next_stopped = 1'b1;
      next_min_tick = 1'b0;
    end
    if (alarm_set & press[BTN_SLEEP]) begin
      next_ahr = inc_wrap(ahr, HR_MAX);
    end
    if (alarm_set & press[BTN_SNOOZE]) begin
      next_amin = inc_wrap(amin, MIN_MAX);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mains_prev <= 1'b1;
      div <= 6'h00;
      sec <= 6'h00;
      tmin <= 6'h00;
      thr <= 6'h00;
      amin <= 6'h00;
      ahr <= 6'h00;
      stopped <= 1'b0;
      min_tick <= 1'b0;
    end else begin
      mains_prev <= next_mains_prev;
      div <= next_div;
      sec <= next_sec;
      tmin <= next_tmin;
      thr <= next_thr;
      amin <= next_amin;
      ahr <= next_ahr;
      stopped <= next_stopped;
      min_tick <= next_min_tick;
    end
  end

  // Alarm and snooze sequencer
  logic [2:0] ctrl, next_ctrl;
  logic [6:0] sleep_per, next_sleep_per;
  logic active, next_active, alt, next_alt, first, next_first, buzz_q, next_buzz_q;
  phase_t phase, next_phase;
  logic [2:0] five, next_five;
  logic [6:0] tout, next_tout, scnt, next_scnt;
  logic hit, point;
  assign hit = min_tick & alarm_req & ~active & (thr == ahr) & (tmin == amin);
  assign point = min_tick & (five == SNOOZE_MIN - 3'h1);

  always_comb begin
    next_active = active;
    next_phase = phase;
    next_alt = alt;
    next_first = first;
    next_five = five;
    next_tout = tout;
    next_scnt = scnt;
    next_buzz_q = ctrl[CTRL_BUZZER];
    if (min_tick && scnt != 7'h00) begin
      next_scnt = scnt - 7'h01;
    end
    if (!alarm_req) begin
      next_active = 1'b0;
      next_phase = PH_IDLE;
    end else if (hit) begin
      next_active = 1'b1;
      next_phase = PH_LOUD;
      next_five = 3'h0;
      next_tout = 7'h00;
      next_alt = 1'b0;
      next_first = 1'b1;
      if (ctrl[CTRL_TAPE]) begin
        next_scnt = sleep_per;
      end
    end else if (active) begin
      if (buzz_q & ~ctrl[CTRL_BUZZER]) begin
        next_alt = 1'b1;
      end
      if (min_tick) begin
        next_five = point ? 3'h0 : five + 3'h1;
        next_tout = tout + 7'h01;
        if (tout == TIMEOUT_MIN - 7'h01) begin
          next_active = 1'b0;
          next_phase = PH_IDLE;
        end else if (point && phase != PH_LOUD) begin
          next_phase = PH_LOUD;
        end
      end
      if (press[BTN_SNOOZE]) begin
        next_tout = 7'h00;
        next_first = 1'b0;
        next_active = 1'b1;
        if (first & ctrl[CTRL_DELAY]) begin
          next_phase = PH_OFF;
        end else begin
          unique case (phase)
            PH_LOUD: next_phase = PH_LOW;
            PH_LOW: next_phase = (alt & ~ctrl[CTRL_BUZZER]) ? PH_LOUD : PH_OFF;
            PH_OFF: next_phase = PH_LOW;
            PH_IDLE: next_phase = PH_LOUD;
          endcase
        end
      end
    end
    if (!active && !time_set && !alarm_set) begin
      if (press[BTN_SLEEP]) begin
        next_scnt = (scnt != 7'h00) ? 7'h00 : sleep_per;
      end else if (press[BTN_SNOOZE]) begin
        next_scnt = 7'h00;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      phase <= PH_IDLE;
      alt <= 1'b0;
      first <= 1'b0;
      five <= 3'h0;
      tout <= 7'h00;
      scnt <= 7'h00;
      buzz_q <= 1'b0;
    end else begin
      active <= next_active;
      phase <= next_phase;
      alt <= next_alt;
      first <= next_first;
      five <= next_five;
      tout <= next_tout;
      scnt <= next_scnt;
      buzz_q <= next_buzz_q;
    end
  end

  // Pin and audio drive; open-drain enables are low while pulling the pin low
  logic loud;
  assign loud = active & (phase == PH_LOUD);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake1_o <= 1'b0;
      wake2_o <= 1'b0;
      sleep_o <= 1'b0;
      wake1_oe_n <= 1'b1;
      wake2_oe_n <= 1'b1;
      sleep_oe_n <= 1'b1;
      radio_on <= 1'b0;
      radio_low_volume <= 1'b0;
      buzzer_on <= 1'b0;
    end else begin
      wake1_o <= 1'b0;
      wake2_o <= 1'b0;
      sleep_o <= 1'b0;
      wake1_oe_n <= ~active;
      wake2_oe_n <= ~loud;
      sleep_oe_n <= (scnt == 7'h00);
      radio_on <= (loud & ~ctrl[CTRL_BUZZER]) | (active & phase == PH_LOW);
      radio_low_volume <= active & (phase == PH_LOW);
      buzzer_on <= loud & ctrl[CTRL_BUZZER];
    end
  end

  // APB slave, answers in the second access cycle
  logic next_pready, next_pslverr, hit_map;
  logic [31:0] next_prdata, rd;
  assign hit_map = (paddr[31:8] == 24'h000000) &
                   (paddr[7:0] == OFF_CTRL || paddr[7:0] == OFF_STATUS || paddr[7:0] == OFF_TIME ||
                    paddr[7:0] == OFF_ALARM || paddr[7:0] == OFF_SLEEP);
  always_comb begin
    rd = 32'h00000000;
    unique case (paddr[7:0])
      OFF_CTRL: rd[2:0] = ctrl;
      OFF_STATUS: begin
        rd[ST_ACTIVE] = active;
        rd[ST_PHASE +: 2] = phase;
        rd[ST_FMT12] = fmt12;
        rd[ST_HZ60] = hz60;
        rd[ST_SLEEP] = (scnt != 7'h00);
        rd[ST_STOPPED] = stopped;
      end
      OFF_TIME: begin
        rd[TM_MIN +: 6] = tmin;
        rd[TM_HR +: 6] = thr;
      end
      OFF_ALARM: begin
        rd[TM_MIN +: 6] = amin;
        rd[TM_HR +: 6] = ahr;
      end
      OFF_SLEEP: rd[6:0] = sleep_per;
      default: rd = 32'h00000000;
    endcase
    if (!hit_map) begin
      rd = 32'h00000000;
    end
    next_pready = psel & penable & ~pready;
    next_pslverr = psel & penable & ~pready & ~hit_map;
    next_prdata = (psel & penable & ~pready & ~pwrite) ? rd : prdata;
    next_ctrl = ctrl;
    next_sleep_per = sleep_per;
    if (psel & penable & pready & pwrite & hit_map) begin
      if (paddr[7:0] == OFF_CTRL) begin
        next_ctrl = pwdata[2:0];
      end
      if (paddr[7:0] == OFF_SLEEP) begin
        // Larger periods clamp to the longest sleep the timer supports
        next_sleep_per = (pwdata[6:0] > SLEEP_MAX_MIN) ? SLEEP_MAX_MIN : pwdata[6:0];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl <= CTRL_RESET;
      sleep_per <= SLEEP_RESET;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      ctrl <= next_ctrl;
      sleep_per <= next_sleep_per;
    end
  end

endmodule : alarm_snooze_wake_sequencer

`default_nettype wire

//--- sim/seq_chk.sv
// Purpose: Port assertions for the alarm, snooze and wake sequencer
// Assumes: Delayed first alarm mode stays off while bound
// Notes: Bound to every instance after endmodule
`timescale 1ns/10ps
`default_nettype none
module seq_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wake1_o,
  input wire logic wake1_oe_n,
  input wire logic wake2_o,
  input wire logic wake2_oe_n,
  input wire logic sleep_o,
  input wire logic radio_on,
  input wire logic radio_low_volume,
  input wire logic buzzer_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && pready;
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer after one wait");
  bad_addr_a: assert property (acc && (paddr > 32'h10 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  good_addr_a: assert property (acc && paddr <= 32'h10 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  low_radio_a: assert property (radio_low_volume |-> radio_on && wake2_oe_n) else $error("low volume wrong");
  buzz_only_a: assert property (buzzer_on |-> !radio_on && !wake2_oe_n) else $error("buzzer with radio");
  audible_wake_a: assert property (!wake2_oe_n |-> !wake1_oe_n) else $error("sound without alarm");
  loud_radio_a: assert property (!wake2_oe_n && !buzzer_on |-> radio_on && !radio_low_volume)
    else $error("wake volume missing");
  drain_zero_a: assert property (!(wake1_o || wake2_o || sleep_o)) else $error("open drain data high");
  reset_idle_a: assert property ($rose(presetn) |-> wake1_oe_n && wake2_oe_n && !radio_on && !buzzer_on)
    else $error("alarm left after reset");
  cover property (acc && pslverr);
  cover property ($rose(radio_low_volume));
  cover property ($rose(buzzer_on));
endmodule : seq_chk
bind alarm_snooze_wake_sequencer seq_chk seq_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .wake1_o(wake1_o),
  .wake1_oe_n(wake1_oe_n), .wake2_o(wake2_o), .wake2_oe_n(wake2_oe_n), .sleep_o(sleep_o),
  .radio_on(radio_on), .radio_low_volume(radio_low_volume), .buzzer_on(buzzer_on));
`default_nettype wire

//--- sim/radio_model.sv
// Purpose: Radio chassis side: mains time base and strapped wake pins
// Assumes: Strap resistors set the wake pin level while released
// Notes: Mains runs far above 50 Hz to keep minutes short
`timescale 1ns/10ps
`default_nettype none
module radio_model (
  input wire logic pclk,
  input wire logic run,
  input wire logic strap12,
  input wire logic strap60,
  input wire logic wake1_o,
  input wire logic wake1_oe_n,
  input wire logic wake2_o,
  input wire logic wake2_oe_n,
  output logic mains,
  output logic wake1_i,
  output logic wake2_i
);
  int cnt = 0;
  initial mains = 1'b0;
  // Two cycles per level, the shortest level the input agreement stage still follows
  always @(posedge pclk) begin
    if (run) begin
      cnt <= (cnt == 1) ? 0 : cnt + 1;
      if (cnt == 1) mains <= !mains;
    end
  end
  assign wake1_i = wake1_oe_n ? strap12 : wake1_o;
  assign wake2_i = wake2_oe_n ? strap60 : wake2_o;
endmodule : radio_model
`default_nettype wire

//--- sim/alarm_snooze_wake_sequencer_tb.sv
// Purpose: Self-checking bench for the alarm, snooze and wake sequencer
// Assumes: Short debounce, fast mains from the partner model
// Notes: The alarm part needs about six simulated minutes
`timescale 1ns/10ps
`default_nettype none
module alarm_snooze_wake_sequencer_tb;
  import snooze_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, w1o, w1n, w2o, w2n, slo, sln, radio_on, low, buzz, mains, w1i, w2i;
  logic st_n = 1'b1, sa_n = 1'b0, sc_n = 1'b1, si_n = 1'b1;
  pins_t pins;
  integer seed = 32'hF3DBA3BB;
  int n_errors = 0, samples_checked = 0, ph = 0, bz = 0, alt = 0, amin = 0, i, v;
  assign pins = pins_t'({mains, st_n, sa_n, sc_n, si_n, w1i, w2i});
  always #5 pclk = ~pclk;
  alarm_snooze_wake_sequencer #(.DEBOUNCE_CYCLES(4)) alarm_snooze_wake_sequencer_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .wake1_o(w1o), .wake1_oe_n(w1n),
    .wake2_o(w2o), .wake2_oe_n(w2n), .sleep_o(slo), .sleep_oe_n(sln), .radio_on(radio_on),
    .radio_low_volume(low), .buzzer_on(buzz));
  radio_model radio_model_i (.pclk(pclk), .run(run), .strap12(1'b1), .strap60(1'b0), .wake1_o(w1o),
    .wake1_oe_n(w1n), .wake2_o(w2o), .wake2_oe_n(w2n), .mains(mains), .wake1_i(w1i), .wake2_i(w2i));
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_out(input string nm);
    logic [4:0] e;
    @(negedge pclk);
    e = {ph == 0, ph != 1, (ph == 1 && bz == 0) || ph == 2, ph == 2, ph == 1 && bz == 1};
    samples_checked++;
    if ({w1n, w2n, radio_on, low, buzz} !== e) begin
      n_errors++;
      $display("unexpected %s expected %b seen %b", nm, e, {w1n, w2n, radio_on, low, buzz});
    end
  endtask : chk_out
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_errors++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic press(input int b, input int hold);
    @(posedge pclk);
    if (b == BTN_SNOOZE) sc_n <= 1'b0;
    else si_n <= 1'b0;
    repeat (hold) @(posedge pclk);
    sc_n <= 1'b1;
    si_n <= 1'b1;
    repeat (20) @(posedge pclk);
  endtask : press
  // One press moves the model one step, whatever the hold time
  task automatic snooze(input int hold);
    press(BTN_SNOOZE, hold);
    ph = (ph == 1) ? 2 : (ph == 2 && alt != 0) ? 1 : (ph == 2) ? 3 : 2;
    chk_out("snooze step");
  endtask : snooze
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (95000) @(posedge pclk);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_out("reset outputs");
    repeat (8) @(posedge pclk);
    run <= 1'b1;
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_reg("status straps", 32'h8, q);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk_reg("ctrl reset", 32'h0, q);
    apb(1'b0, OFF_SLEEP, 32'h0);
    chk_reg("sleep reset", {25'h0, SLEEP_RESET}, q);
    apb(1'b0, 8'h14, 32'h0);
    chk_reg("unmapped error", 32'h1, {31'h0, err});
    chk_reg("unmapped data", 32'h0, q);
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'h79 : $random(seed) & 32'h7F;
      apb(1'b1, OFF_SLEEP, v);
      apb(1'b0, OFF_SLEEP, 32'h0);
      chk_reg("sleep clamp", (v > 32'h78) ? 32'h78 : v, q);
    end
    $display("test registers done");
    for (i = 0; i < 61; i++) press(BTN_SNOOZE, 12 + ($random(seed) & 7));
    for (i = 0; i < 24; i++) press(BTN_SLEEP, 12 + ($random(seed) & 7));
    // Too short to survive the debounce
    press(BTN_SNOOZE, 2);
    amin = 61 % 60;
    apb(1'b0, OFF_ALARM, 32'h0);
    chk_reg("alarm set", amin, q);
    $display("test alarm setting done");
    @(posedge pclk);
    st_n <= 1'b0;
    i = 0;
    while (w1n !== 1'b0 && i < 30000) begin
      @(negedge pclk);
      i++;
    end
    if (w1n !== 1'b0) n_errors++;
    ph = 1;
    repeat (4) @(posedge pclk);
    chk_out("alarm start");
    for (i = 0; i < 4; i++) snooze(12 + ($random(seed) & 7));
    snooze(300);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_reg("status phase", 32'h9 | (ph << 1), q);
    apb(1'b1, OFF_CTRL, 32'h1);
    bz = 1;
    chk_out("buzzer select");
    $display("test radio snooze done");
    i = 0;
    while (w2n !== 1'b0 && i < 70000) begin
      @(negedge pclk);
      i++;
    end
    if (w2n !== 1'b0) n_errors++;
    ph = 1;
    repeat (4) @(posedge pclk);
    chk_out("snooze point");
    apb(1'b0, OFF_TIME, 32'h0);
    chk_reg("point minute", amin + 5, q);
    snooze(16);
    snooze(16);
    apb(1'b1, OFF_CTRL, 32'h0);
    bz = 0;
    alt = 1;
    chk_out("radio select");
    snooze(16);
    snooze(16);
    @(posedge pclk);
    st_n <= 1'b1;
    repeat (12) @(posedge pclk);
    st_n <= 1'b0;
    ph = 0;
    repeat (12) @(posedge pclk);
    chk_out("cancelled");
    apb(1'b0, OFF_ALARM, 32'h0);
    chk_reg("alarm kept", amin, q);
    $display("test buzzer and cancel done");
    apb(1'b1, OFF_SLEEP, 32'hA);
    press(BTN_SLEEP, 16);
    chk_reg("sleep on", 32'h0, {31'h0, sln});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_reg("sleep status", 32'h28, q);
    press(BTN_SNOOZE, 16);
    chk_reg("sleep off", 32'h1, {31'h0, sln});
    @(posedge pclk);
    sa_n <= 1'b1;
    repeat (12) @(posedge pclk);
    press(BTN_SNOOZE, 16);
    press(BTN_SLEEP, 16);
    apb(1'b0, OFF_TIME, 32'h0);
    chk_reg("time set", 32'h100 | (amin + 6), q);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_reg("clock stopped", 32'h48, q);
    $display("test sleep and time setting done");
    final_report();
  end
endmodule : alarm_snooze_wake_sequencer_tb
`default_nettype wire
